/* File: inc/tbw_defines.vh */
// Constants, register map and field layout of the time-base and watchdog unit
// Summary of operation
// - Time-base counter is an 18-bit free-running up-counter on the main clock.
// - Two-bit select picks interval 2^12, 2^14, 2^16 or 2^19 oscillation periods; the code gives 2^11, 2^13, 2^15 or 2^18.
// - Carry out of the selected counter bit sets the time-base overflow flag.
// - Time-base interrupt request is raised while flag set and its enable is one.
// - Counter bits are supplied as divided clocks to other units.
// - Time-base request belongs to interrupt number 16 (10 hex).
// - Two-bit watchdog counter on a chosen carry; unkicked it resets the CPU.
// - Watchdog reset lands between a minimum and maximum set by count clock.
// - Clock-source select bit in clock timer control picks time-base or clock timer.
// - Two-bit watchdog interval field picks the tap used as count clock.
// - Time-base source gives 2^14, 2^16, 2^18 or 2^21 periods, plus or minus; the code gives 2^13, 2^15, 2^17 or 2^20.
// - Clock-timer source gives 2^12, 2^15, 2^16 or 2^17 sub-clock periods, plus or minus.
// - Clearing the time-base counter may lengthen the watchdog time; allowed.
// - Clock timer is a 15-bit free-running up-counter on the sub clock.
`ifndef TBW_DEFINES_VH
`define TBW_DEFINES_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TBW_TB_WIDTH 18
`define TBW_CT_WIDTH 15
`define TBW_ADDR_WIDTH 8

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TBW_OFS_TB_CTRL 8'h00
`define TBW_OFS_CT_CTRL 8'h04
`define TBW_OFS_WD_CTRL 8'h08
`define TBW_OFS_INT_STAT 8'h0c
`define TBW_OFS_INT_MASK 8'h10
`define TBW_OFS_TB_COUNT 8'h14
`define TBW_OFS_CT_COUNT 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define TBW_TB_SEL_LO 0
`define TBW_TB_SEL_HI 1
`define TBW_TB_IRQ_EN 2
`define TBW_TB_FLAG 3
`define TBW_TB_CLEAR 4
`define TBW_TB_IRQNUM_LSB 8
`define TBW_CT_WD_SRC 0
`define TBW_CT_CLEAR 1
`define TBW_WD_SEL_LO 0
`define TBW_WD_SEL_HI 1
`define TBW_WD_KICK 2
`define TBW_WD_ACTIVE 4
`define TBW_WD_CNT_LSB 8
`define TBW_INT_TB 0
`define TBW_INT_CT 1
`define TBW_INT_WD 2

// ----------------------------------------
// Reset values and fixed codes
// ----------------------------------------
`define TBW_TB_IRQ_NUM 8'h10
`define TBW_WD_SRC_RESET 1'b1
`define TBW_INT_BITS 3

// ----------------------------------------
// Counter taps (bit whose carry-out marks the interval)
// ----------------------------------------
`define TBW_TB_TAP0 10
`define TBW_TB_TAP1 12
`define TBW_TB_TAP2 14
`define TBW_TB_TAP3 17
`define TBW_CT_TAP0 9
`define TBW_CT_TAP1 12
`define TBW_CT_TAP2 13
`define TBW_CT_TAP3 14
`define TBW_CT_INT_TAP 14

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define TBW_RESP_OKAY 2'b00
`define TBW_RESP_SLVERR 2'b10

`endif

/* File: verilog/tbw_clock_timer.v */
// Sub-clock driven free-running clock timer with per-bit carry pulses
`timescale 1ns/1ps
`default_nettype none
`include "tbw_defines.vh"

module tbw_clock_timer #(
    parameter WIDTH = `TBW_CT_WIDTH
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Control
    input wire subClkTick,
    input wire ctClear,
    // Status
    output reg [WIDTH-1:0] ctCount,
    output reg [WIDTH-1:0] ctCarry
);

// ----------------------------------------
// Carry chain
// ----------------------------------------
wire [WIDTH-1:0] ctAllOnes;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gCarry
        if (i == 0)
        begin : gFirst
            assign ctAllOnes[i] = ctCount[i];
        end
        else
        begin : gRest
            assign ctAllOnes[i] = ctAllOnes[i-1] & ctCount[i];
        end
        // Pulse when this bit carries out on the next count
        always @(posedge mclk)
        begin
            if (rst)
                ctCarry[i] <= 1'b0;
            else
                ctCarry[i] <= subClkTick & ~ctClear & ctAllOnes[i];
        end
    end
endgenerate

// ----------------------------------------
// Counter
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
        ctCount <= {WIDTH{1'b0}};
    else if (ctClear)
        ctCount <= {WIDTH{1'b0}};
    else if (subClkTick)
        ctCount <= ctCount + {{(WIDTH-1){1'b0}}, 1'b1};
end

endmodule
`default_nettype wire

/* File: verilog/tbw_timebase_watchdog.v */
// Time-base interval timer and watchdog with an AXI4-Lite register slave
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tbw_defines.vh"

module tbw_timebase_watchdog #(
    parameter TB_WIDTH = `TBW_TB_WIDTH,
    parameter CT_WIDTH = `TBW_CT_WIDTH
) (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Sub clock, one mclk-wide pulse per sub-clock period
    input wire subClkTick,
    // AXI4-Lite write address
    input wire [`TBW_ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [`TBW_ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Divided clocks and requests
    output reg [TB_WIDTH-1:0] tbDiv,
    output reg tbIrq,
    output reg irq,
    output reg wdCpuReset
);

// ----------------------------------------
// State
// ----------------------------------------
reg [1:0] tbIntervalSel;
reg tbIrqEnable;
reg tbOverflowFlag;
reg wdClockSourceSel;
reg [1:0] wdIntervalSel;
reg wdActive;
reg [1:0] wdCount;
reg [`TBW_INT_BITS-1:0] intStatus;
reg [`TBW_INT_BITS-1:0] intMask;
reg [31:0] next_rdata;
reg next_rdOk;
reg tbTapCarry;
reg wdSkip;
wire wdTbCarry;
wire wdCtCarry;
wire wdPhase;
wire [3:0] tbTapCarries;
wire [3:0] ctTapCarries;
wire [3:0] tbTapPhases;
wire [3:0] ctTapPhases;
wire [CT_WIDTH-1:0] ctCount;
wire [CT_WIDTH-1:0] ctCarry;
wire [TB_WIDTH-1:0] tbAllOnes;
wire wrFire;
wire wrByte0;
wire tbClear;
wire ctClear;
wire wdKick;
wire wdTick;
wire wdExpire;
wire tbSet;
wire [`TBW_INT_BITS-1:0] intEvents;
wire [`TBW_INT_BITS-1:0] next_intStatus;

// ----------------------------------------
// Write decode
// ----------------------------------------
// Address and data are taken together in one handshake
assign wrFire = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
assign wrByte0 = wrFire & s_axi_wstrb[0];
assign tbClear = wrByte0 & (s_axi_awaddr == `TBW_OFS_TB_CTRL)
    & s_axi_wdata[`TBW_TB_CLEAR];
assign ctClear = wrByte0 & (s_axi_awaddr == `TBW_OFS_CT_CTRL)
    & s_axi_wdata[`TBW_CT_CLEAR];
assign wdKick = wrByte0 & (s_axi_awaddr == `TBW_OFS_WD_CTRL)
    & s_axi_wdata[`TBW_WD_KICK];

// ----------------------------------------
// Time-base counter
// ----------------------------------------
genvar i;
generate
    for (i = 0; i < TB_WIDTH; i = i + 1)
    begin : gTbCarry
        if (i == 0)
        begin : gFirst
            assign tbAllOnes[i] = tbDiv[i];
        end
        else
        begin : gRest
            assign tbAllOnes[i] = tbAllOnes[i-1] & tbDiv[i];
        end
    end
endgenerate

// Counter doubles as the divided-clock output bus
always @(posedge mclk)
begin
    if (rst)
        tbDiv <= {TB_WIDTH{1'b0}};
    else if (tbClear)
        tbDiv <= {TB_WIDTH{1'b0}};
    else
        tbDiv <= tbDiv + {{(TB_WIDTH-1){1'b0}}, 1'b1};
end

// Carry of the selected interval bit; a clear swallows it
always @*
begin
    case (tbIntervalSel)
        2'd0: tbTapCarry = tbAllOnes[`TBW_TB_TAP0];
        2'd1: tbTapCarry = tbAllOnes[`TBW_TB_TAP1];
        2'd2: tbTapCarry = tbAllOnes[`TBW_TB_TAP2];
        2'd3: tbTapCarry = tbAllOnes[`TBW_TB_TAP3];
        default: tbTapCarry = 1'b0;
    endcase
end

assign tbSet = tbTapCarry & ~tbClear;

// ----------------------------------------
// Clock timer
// ----------------------------------------
tbw_clock_timer #(
    .WIDTH(CT_WIDTH)
) uClockTimer (
    .mclk(mclk),
    .rst(rst),
    .subClkTick(subClkTick),
    .ctClear(ctClear),
    .ctCount(ctCount),
    .ctCarry(ctCarry)
);

// ----------------------------------------
// Watchdog
// ----------------------------------------
// Carries and phase bits per interval code, code 0 in bit 0
assign tbTapCarries = {tbAllOnes[`TBW_TB_TAP3], tbAllOnes[`TBW_TB_TAP2],
    tbAllOnes[`TBW_TB_TAP1], tbAllOnes[`TBW_TB_TAP0]};
assign ctTapCarries = {ctCarry[`TBW_CT_TAP3], ctCarry[`TBW_CT_TAP2],
    ctCarry[`TBW_CT_TAP1], ctCarry[`TBW_CT_TAP0]};
assign tbTapPhases = {tbDiv[`TBW_TB_TAP3], tbDiv[`TBW_TB_TAP2],
    tbDiv[`TBW_TB_TAP1], tbDiv[`TBW_TB_TAP0]};
assign ctTapPhases = {ctCount[`TBW_CT_TAP3], ctCount[`TBW_CT_TAP2],
    ctCount[`TBW_CT_TAP1], ctCount[`TBW_CT_TAP0]};
assign wdTbCarry = tbTapCarries[wdIntervalSel];
assign wdCtCarry = ctTapCarries[wdIntervalSel];
// Tap bit high: the next carry is at most half a period away
assign wdPhase = wdClockSourceSel ? tbTapPhases[wdIntervalSel] : ctTapPhases[wdIntervalSel];

// Clearing the time-base restarts its carry, so the wait may stretch
assign wdTick = wdClockSourceSel ? (wdTbCarry & ~tbClear) : wdCtCarry;
// Fourth counted carry ends the wait: reset lies 3.5 to 4.5 periods after a kick
assign wdExpire = wdActive & wdTick & ~wdSkip & (wdCount == 2'd3) & ~wdKick;

always @(posedge mclk)
begin
    if (rst)
    begin
        wdActive <= 1'b0;
        wdCount <= 2'd0;
        wdSkip <= 1'b0;
        wdCpuReset <= 1'b0;
    end
    else
    begin
        wdCpuReset <= wdExpire;
        if (wdKick)
        begin
            // Kick late in a period skips the next carry; phase from the old tap
            wdActive <= 1'b1;
            wdCount <= 2'd0;
            wdSkip <= wdPhase & ~wdTick;
        end
        else if (wdActive & wdTick & wdSkip)
            wdSkip <= 1'b0;
        else if (wdActive & wdTick)
            wdCount <= wdCount + 2'd1;
    end
end

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
    begin
        tbIntervalSel <= 2'd0;
        tbIrqEnable <= 1'b0;
        tbOverflowFlag <= 1'b0;
        wdClockSourceSel <= `TBW_WD_SRC_RESET;
        wdIntervalSel <= 2'd0;
        intMask <= {`TBW_INT_BITS{1'b0}};
    end
    else
    begin
        if (wrByte0 & (s_axi_awaddr == `TBW_OFS_TB_CTRL))
        begin
            tbIntervalSel <= s_axi_wdata[`TBW_TB_SEL_HI:`TBW_TB_SEL_LO];
            tbIrqEnable <= s_axi_wdata[`TBW_TB_IRQ_EN];
        end
        if (wrByte0 & (s_axi_awaddr == `TBW_OFS_CT_CTRL))
            wdClockSourceSel <= s_axi_wdata[`TBW_CT_WD_SRC];
        if (wrByte0 & (s_axi_awaddr == `TBW_OFS_WD_CTRL))
            wdIntervalSel <= s_axi_wdata[`TBW_WD_SEL_HI:`TBW_WD_SEL_LO];
        if (wrByte0 & (s_axi_awaddr == `TBW_OFS_INT_MASK))
            intMask <= s_axi_wdata[`TBW_INT_BITS-1:0];
        // Set beats a same-cycle clear; a written one is ignored
        if (tbSet)
            tbOverflowFlag <= 1'b1;
        else if (wrByte0 & (s_axi_awaddr == `TBW_OFS_TB_CTRL)
            & ~s_axi_wdata[`TBW_TB_FLAG])
            tbOverflowFlag <= 1'b0;
    end
end

// ----------------------------------------
// Interrupts
// ----------------------------------------
assign intEvents = {wdExpire, ctCarry[`TBW_CT_INT_TAP], tbSet};
assign next_intStatus = (intStatus
    & ~({`TBW_INT_BITS{wrByte0 & (s_axi_awaddr == `TBW_OFS_INT_STAT)}}
    & s_axi_wdata[`TBW_INT_BITS-1:0])) | intEvents;

always @(posedge mclk)
begin
    if (rst)
    begin
        intStatus <= {`TBW_INT_BITS{1'b0}};
        irq <= 1'b0;
        tbIrq <= 1'b0;
    end
    else
    begin
        intStatus <= next_intStatus;
        irq <= |(next_intStatus & intMask);
        // Request line for interrupt number 16
        tbIrq <= tbIrqEnable & (tbOverflowFlag | tbSet);
    end
end

// ----------------------------------------
// AXI write channel
// ----------------------------------------
always @(posedge mclk)
begin
    if (rst)
    begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TBW_RESP_OKAY;
    end
    else
    begin
        s_axi_awready <= wrFire;
        s_axi_wready <= wrFire;
        if (wrFire)
        begin
            s_axi_bvalid <= 1'b1;
            case (s_axi_awaddr)
                `TBW_OFS_TB_CTRL, `TBW_OFS_CT_CTRL, `TBW_OFS_WD_CTRL,
                `TBW_OFS_INT_STAT, `TBW_OFS_INT_MASK, `TBW_OFS_TB_COUNT,
                `TBW_OFS_CT_COUNT: s_axi_bresp <= `TBW_RESP_OKAY;
                default: s_axi_bresp <= `TBW_RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
end

// ----------------------------------------
// AXI read channel
// ----------------------------------------
always @*
begin
    next_rdata = 32'h00000000;
    next_rdOk = 1'b1;
    case (s_axi_araddr)
        `TBW_OFS_TB_CTRL:
        begin
            next_rdata[`TBW_TB_SEL_HI:`TBW_TB_SEL_LO] = tbIntervalSel;
            next_rdata[`TBW_TB_IRQ_EN] = tbIrqEnable;
            next_rdata[`TBW_TB_FLAG] = tbOverflowFlag;
            next_rdata[`TBW_TB_IRQNUM_LSB+7:`TBW_TB_IRQNUM_LSB] = `TBW_TB_IRQ_NUM;
        end
        `TBW_OFS_CT_CTRL: next_rdata[`TBW_CT_WD_SRC] = wdClockSourceSel;
        `TBW_OFS_WD_CTRL:
        begin
            next_rdata[`TBW_WD_SEL_HI:`TBW_WD_SEL_LO] = wdIntervalSel;
            next_rdata[`TBW_WD_ACTIVE] = wdActive;
            next_rdata[`TBW_WD_CNT_LSB+1:`TBW_WD_CNT_LSB] = wdCount;
        end
        `TBW_OFS_INT_STAT: next_rdata[`TBW_INT_BITS-1:0] = intStatus;
        `TBW_OFS_INT_MASK: next_rdata[`TBW_INT_BITS-1:0] = intMask;
        `TBW_OFS_TB_COUNT: next_rdata[TB_WIDTH-1:0] = tbDiv;
        `TBW_OFS_CT_COUNT: next_rdata[CT_WIDTH-1:0] = ctCount;
        default: next_rdOk = 1'b0;
    endcase
end

always @(posedge mclk)
begin
    if (rst)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `TBW_RESP_OKAY;
    end
    else
    begin
        s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
        if (s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rdOk ? `TBW_RESP_OKAY : `TBW_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

endmodule
`default_nettype wire

/* File: test/tbw_timebase_watchdog_chk.sv */
// Port-level assertions for the time-base and watchdog unit
`timescale 1ns/1ps
`default_nettype none

module tbw_timebase_watchdog_chk #(
    parameter TB_WIDTH = 18
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer outputs
    input wire logic [TB_WIDTH-1:0] tbDiv,
    input wire logic tbIrq,
    input wire logic irq,
    input wire logic wdCpuReset
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ----------------
    // Bus sequences
    // ----------------
    sequence wrTake;
        s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    endsequence
    sequence wrAnswer;
        s_axi_awready && s_axi_wready && s_axi_bvalid;
    endsequence
    sequence rdTake;
        s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    endsequence
    sequence rdAnswer;
        s_axi_arready && s_axi_rvalid;
    endsequence

    // ----------------
    // Checks
    // ----------------
    write_answer_a: assert property (wrTake |=> wrAnswer)
        else $error("write not answered next cycle");
    read_answer_a: assert property (rdTake |=> rdAnswer)
        else $error("read not answered next cycle");
    write_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    reset_clear_a: assert property ($past(rst) |-> tbDiv == '0 && !tbIrq && !irq && !wdCpuReset)
        else $error("outputs not cleared by reset");
    tb_count_a: assert property (!$past(rst) |-> tbDiv == $past(tbDiv) + 1'b1 || tbDiv == '0)
        else $error("time-base counter skipped");
    wd_pulse_a: assert property (wdCpuReset |=> !wdCpuReset)
        else $error("watchdog reset pulse too long");
    tbirq_rise_a: assert property ($rose(tbIrq) |-> tbDiv[9:0] == 10'h000
        || $past(s_axi_awready) || $past(s_axi_awready, 2))
        else $error("time-base request off the carry");
    tbirq_fall_a: assert property ($fell(tbIrq) |-> $past(s_axi_awready) || $past(s_axi_awready, 2))
        else $error("time-base request dropped without a write");
    irq_fall_a: assert property ($fell(irq) |-> s_axi_awready || $past(s_axi_awready))
        else $error("interrupt dropped without a write");
endmodule

bind tbw_timebase_watchdog tbw_timebase_watchdog_chk #(.TB_WIDTH(TB_WIDTH)) chk (
    .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .tbDiv, .tbIrq, .irq, .wdCpuReset
);

`default_nettype wire

/* File: test/test_tbw_timebase_watchdog.sv */
// Self-checking bench for the time-base and watchdog unit
`timescale 1ns/1ps
`default_nettype none
`include "tbw_defines.vh"

module test_tbw_timebase_watchdog;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] br;
        logic [31:0] rd;
        logic [1:0] rr;
    } tbw_row_t;
    localparam logic [31:0] IRQN = {16'h0000, `TBW_TB_IRQ_NUM, 8'h00};
    localparam logic [1:0] OK = `TBW_RESP_OKAY;
    localparam logic [1:0] ERR = `TBW_RESP_SLVERR;
    localparam tbw_row_t ROWS [8] = '{
        '{8'h00, 32'h03, OK, IRQN | 32'h03, OK},
        '{8'h00, 32'h08, OK, IRQN, OK},
        '{8'h04, 32'h00, OK, 32'h0, OK},
        '{8'h04, 32'h01, OK, 32'h1, OK},
        '{8'h08, 32'h03, OK, 32'h3, OK},
        '{8'h10, 32'h07, OK, 32'h7, OK},
        '{8'h10, 32'h00, OK, 32'h0, OK},
        '{8'h20, 32'h05, ERR, 32'h0, ERR}
    };
    localparam logic [31:0] RST_EXP [4] = '{IRQN, 32'h1, 32'h0, 32'h0};

    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic subClkTick = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic tbIrq, irq, wdCpuReset;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, data;
    logic [`TBW_TB_WIDTH-1:0] tbDiv;
    int badCount = 0, testsRun = 0, wdSeen = 0, cyc;

    tbw_timebase_watchdog uut (
        .mclk, .rst, .subClkTick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tbDiv, .tbIrq,
        .irq, .wdCpuReset
    );
    tbw_timebase_watchdog_chk chk (
        .mclk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
        .s_axi_rready, .tbDiv, .tbIrq, .irq, .wdCpuReset
    );

    initial
    begin
        forever #2 mclk = ~mclk;
    end

    always @(posedge mclk)
        if (wdCpuReset === 1'b1) wdSeen <= wdSeen + 1;

    // ----------------
    // Tasks
    // ----------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            badCount++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Every wait is bounded; running out ends the run
    task automatic guard(input int n, input int lim);
        if (n >= lim)
        begin
            badCount++;
            $display("MISMATCH at %0t: wait ran out", $time);
            summarize();
        end
    endtask

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            guard(n, 50);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask

    task automatic axiRead(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
            guard(n, 50);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        data = s_axi_rdata;
        resp = s_axi_rresp;
    endtask

    // Counts edges from the call until the chosen output is seen high
    task automatic waitHigh(input logic wd, input int lim);
        cyc = 0;
        do
        begin
            @(posedge mclk);
            cyc++;
            guard(cyc, lim);
        end
        while ((wd ? wdCpuReset : tbIrq) !== 1'b1);
    endtask

    task automatic inRange(input int lo, input int hi);
        check(32'(cyc >= lo && cyc <= hi), 32'h1);
    endtask

    // ----------------
    // Sequence
    // ----------------
    initial
    begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        foreach (ROWS[i])
        begin
            axiWrite(ROWS[i].a, ROWS[i].d);
            check(resp, ROWS[i].br);
            axiRead(ROWS[i].a);
            check(data, ROWS[i].rd);
            check(resp, ROWS[i].rr);
        end
        $display("test register rows done");
        axiWrite(8'h00, 32'h10);
        repeat (2100) @(posedge mclk);
        check(tbIrq, 1'b0);
        axiWrite(8'h00, 32'h08);
        axiRead(8'h00);
        check(data, IRQN | 32'h08);
        axiWrite(8'h00, 32'h00);
        axiRead(8'h00);
        check(data, IRQN);
        // Interval measured from a counter clear, one for each of select codes 0 to 2
        for (int s = 0; s < 3; s++)
        begin
            axiWrite(8'h00, 32'h14 | s);
            waitHigh(1'b0, 40000);
            inRange((1 << (11 + 2 * s)) - 4, (1 << (11 + 2 * s)) + 4);
            axiRead(8'h00);
            check(data, IRQN | 32'h0c | s);
            axiWrite(8'h00, s);
        end
        $display("test intervals done");
        axiRead(8'h0c);
        check(data, 32'h1);
        check(irq, 1'b0);
        axiWrite(8'h10, 32'h1);
        @(posedge mclk);
        check(irq, 1'b1);
        axiWrite(8'h0c, 32'h1);
        @(posedge mclk);
        check(irq, 1'b0);
        axiWrite(8'h10, 32'h0);
        $display("test interrupt done");
        repeat (3)
        begin
            axiWrite(8'h08, 32'h04);
            repeat (5000) @(posedge mclk);
        end
        check(wdSeen, 0);
        axiWrite(8'h08, 32'h04);
        waitHigh(1'b1, 10000);
        inRange(7168, 9216);
        axiRead(8'h0c);
        check(data & 32'h4, 32'h4);
        axiRead(8'h08);
        check(data & 32'h13, 32'h10);
        $display("test watchdog time-base done");
        subClkTick <= 1'b1;
        axiWrite(8'h04, 32'h02);
        axiRead(8'h18);
        check(data, 32'h2);
        axiWrite(8'h08, 32'h04);
        waitHigh(1'b1, 5000);
        inRange(3584, 4608);
        subClkTick <= 1'b0;
        $display("test watchdog clock timer done");
        rst <= 1'b1;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            axiRead(8'(4 * i));
            check(data, RST_EXP[i]);
        end
        check(irq, 1'b0);
        $display("test reset done");
        summarize();
    end
endmodule

`default_nettype wire
